// ### design/ssr_status_summary.sv
// status summary block: condition, event and enable groups, status byte
`include "ssr_defines.svh"
`default_nettype none

module ssr_status_summary #(
	parameter int NUM_CH = `SSR_MAX_CH
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// live conditions from the digitizer
	input wire ssr_pkg::ssr_oper_cond_type oper_cond,
	input wire ssr_pkg::ssr_ques_cond_type ques_cond,
	input wire ssr_pkg::ssr_ext_sum_type ext_sum,
	// host command port
	input wire ssr_pkg::ssr_req_type req,
	output var ssr_pkg::ssr_rsp_type rsp,
	// status byte
	output var logic [`SSR_STB_W-1:0] status_summary_byte
);

	if (NUM_CH < 1 || NUM_CH > `SSR_MAX_CH) begin : g_bad_ch
		$error("NUM_CH must lie between 1 and 4");
	end

	// the header map must leave room for every limit bit
	if (`SSR_QUES_LIMIT0_BIT + `SSR_MAX_CH > `SSR_GRP_W) begin : g_bad_map
		$error("limit bits run past the questionable group");
	end

	////////////////////////////////////////////////////////////////////////////
	// condition mapping

	logic [`SSR_GRP_W-1:0] oper_live;
	logic [`SSR_GRP_W-1:0] ques_live;
	logic [`SSR_GRP_W-1:0] ques_limit;

	genvar ch;
	for (ch = 0; ch < `SSR_MAX_CH; ch++) begin : g_limit
		if (ch < NUM_CH) begin : g_used
			assign ques_limit[`SSR_QUES_LIMIT0_BIT + ch] =
				ques_cond.limit_fail[ch];
		end else begin : g_unused
			assign ques_limit[`SSR_QUES_LIMIT0_BIT + ch] = 1'b0;
		end
	end
	assign ques_limit[`SSR_QUES_LIMIT0_BIT-1:0] = '0;
	assign ques_limit[`SSR_GRP_W-1:`SSR_QUES_LIMIT0_BIT+`SSR_MAX_CH] = '0;

	always_comb begin
		oper_live = '0;
		oper_live[`SSR_OPER_CALACT_BIT] = oper_cond.cal_active;
		oper_live[`SSR_OPER_WAITTRIG_BIT] = oper_cond.awaiting_trig;
		oper_live[`SSR_OPER_PRETRIG_BIT] = oper_cond.pretrig_met;
		oper_live[`SSR_OPER_DONE_BIT] = oper_cond.meas_done;
		ques_live = ques_limit;
		ques_live[`SSR_QUES_OVERLOAD_BIT] = ques_cond.overload;
		ques_live[`SSR_QUES_CALFAIL_BIT] = ques_cond.cal_fail;
	end

	////////////////////////////////////////////////////////////////////////////
	// command decode

	// one place decides whether a request names a given write, preset or event-read command; read data uses its own case on req.op
	function automatic logic is_op(ssr_pkg::ssr_req_type r,
		ssr_pkg::ssr_cmd_type op);
		return r.valid && (r.op == op);
	endfunction : is_op

	wire oper_evt_rd = is_op(req, ssr_pkg::SSR_OPER_EVT_RD);
	wire ques_evt_rd = is_op(req, ssr_pkg::SSR_QUES_EVT_RD);
	wire oper_en_wr = is_op(req, ssr_pkg::SSR_OPER_EN_WR);
	wire ques_en_wr = is_op(req, ssr_pkg::SSR_QUES_EN_WR);
	wire preset = is_op(req, ssr_pkg::SSR_PRESET);

	////////////////////////////////////////////////////////////////////////////
	// condition, event and enable registers

	logic [`SSR_GRP_W-1:0] oper_cond_r;
	logic [`SSR_GRP_W-1:0] ques_cond_r;
	logic [`SSR_GRP_W-1:0] oper_event_r;
	logic [`SSR_GRP_W-1:0] oper_event_nxt;
	logic [`SSR_GRP_W-1:0] ques_event_r;
	logic [`SSR_GRP_W-1:0] ques_event_nxt;
	logic [`SSR_GRP_W-1:0] oper_enable_r;
	logic [`SSR_GRP_W-1:0] oper_enable_nxt;
	logic [`SSR_GRP_W-1:0] ques_enable_r;
	logic [`SSR_GRP_W-1:0] ques_enable_nxt;

	// a condition active in the clearing cycle is kept, so no event is lost
	assign oper_event_nxt = (oper_evt_rd ? '0 : oper_event_r)
		| oper_live;
	assign ques_event_nxt = (ques_evt_rd ? '0 : ques_event_r)
		| ques_live;

	// preset wins over a write in the same cycle; events are not touched
	assign oper_enable_nxt = preset ? `SSR_ENABLE_RST :
		(oper_en_wr ? req.data : oper_enable_r);
	assign ques_enable_nxt = preset ? `SSR_ENABLE_RST :
		(ques_en_wr ? req.data : ques_enable_r);

	// copies of the live inputs, read back by the condition queries
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			oper_cond_r <= `SSR_COND_RST;
		end else begin
			oper_cond_r <= oper_live;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ques_cond_r <= `SSR_COND_RST;
		end else begin
			ques_cond_r <= ques_live;
		end
	end

	// event latches: set wins over the read clear
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			oper_event_r <= `SSR_EVENT_RST;
		end else begin
			oper_event_r <= oper_event_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ques_event_r <= `SSR_EVENT_RST;
		end else begin
			ques_event_r <= ques_event_nxt;
		end
	end

	// enables change only on a write, a preset or reset
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			oper_enable_r <= `SSR_ENABLE_RST;
		end else begin
			oper_enable_r <= oper_enable_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ques_enable_r <= `SSR_ENABLE_RST;
		end else begin
			ques_enable_r <= ques_enable_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// summaries and status byte

	// masked-off events never leak into the byte
	wire oper_summary =
		|(oper_event_r & oper_enable_r);
	wire ques_summary =
		|(ques_event_r & ques_enable_r);

	logic [`SSR_STB_W-1:0] stb_nxt;
	always_comb begin
		stb_nxt = '0;
		stb_nxt[`SSR_STB_OPER_BIT] = oper_summary;
		stb_nxt[`SSR_STB_STD_EVT_BIT] = ext_sum.std_event_summary;
		stb_nxt[`SSR_STB_MSG_AVAIL_BIT] =
			ext_sum.message_available_bit;
		stb_nxt[`SSR_STB_BIT4] = ext_sum.aux_bit4;
		stb_nxt[`SSR_STB_QUES_BIT] = ques_summary;
	end

	////////////////////////////////////////////////////////////////////////////
	// read data; writes and preset answer with zero as an acknowledge

	logic [`SSR_GRP_W-1:0] rd_data;
	always_comb begin
		case (req.op)
			ssr_pkg::SSR_OPER_COND_RD: rd_data = oper_cond_r;
			ssr_pkg::SSR_OPER_EVT_RD: rd_data = oper_event_r;
			ssr_pkg::SSR_OPER_EN_RD: rd_data = oper_enable_r;
			ssr_pkg::SSR_QUES_COND_RD: rd_data = ques_cond_r;
			ssr_pkg::SSR_QUES_EVT_RD: rd_data = ques_event_r;
			ssr_pkg::SSR_QUES_EN_RD: rd_data = ques_enable_r;
			ssr_pkg::SSR_STB_RD: rd_data = {8'h00, status_summary_byte};
			default: rd_data = 16'h0000;
		endcase
	end

	// byte rebuilt every cycle, so it always follows the masks
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			status_summary_byte <= `SSR_STB_RST;
		end else begin
			status_summary_byte <= stb_nxt;
		end
	end

	// every command answered one cycle later, writes with zero
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.valid;
			rsp.data <= req.valid ? rd_data : 16'h0000;
		end
	end

endmodule : ssr_status_summary
`default_nettype wire

// ### design/ssr_defines.svh
// bit positions, widths and reset values of the status summary block
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

`define SSR_GRP_W 16
`define SSR_STB_W 8
`define SSR_ENABLE_RST 16'h0000
`define SSR_EVENT_RST 16'h0000
`define SSR_STB_RST 8'h00
`define SSR_COND_RST 16'h0000

`define SSR_QUES_OVERLOAD_BIT 0
`define SSR_QUES_CALFAIL_BIT 8
`define SSR_QUES_LIMIT0_BIT 9

`define SSR_OPER_CALACT_BIT 0
`define SSR_OPER_WAITTRIG_BIT 5
`define SSR_OPER_PRETRIG_BIT 8
`define SSR_OPER_DONE_BIT 9

`define SSR_STB_QUES_BIT 3
`define SSR_STB_BIT4 4
`define SSR_STB_MSG_AVAIL_BIT 5
`define SSR_STB_STD_EVT_BIT 6
`define SSR_STB_OPER_BIT 7

`define SSR_MAX_CH 4

`endif

// ### design/ssr_pkg.sv
// types shared by the status summary block
`default_nettype none
package ssr_pkg;

	typedef enum logic [3:0] {
		SSR_OPER_COND_RD = 4'h0,
		SSR_OPER_EVT_RD = 4'h1,
		SSR_OPER_EN_RD = 4'h2,
		SSR_OPER_EN_WR = 4'h3,
		SSR_QUES_COND_RD = 4'h4,
		SSR_QUES_EVT_RD = 4'h5,
		SSR_QUES_EN_RD = 4'h6,
		SSR_QUES_EN_WR = 4'h7,
		SSR_PRESET = 4'h8,
		SSR_STB_RD = 4'h9
	} ssr_cmd_type;

	typedef struct packed {
		logic valid;
		ssr_cmd_type op;
		logic [15:0] data;
	} ssr_req_type;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} ssr_rsp_type;

	typedef struct packed {
		logic meas_done;
		logic pretrig_met;
		logic awaiting_trig;
		logic cal_active;
	} ssr_oper_cond_type;

	typedef struct packed {
		logic [3:0] limit_fail;
		logic cal_fail;
		logic overload;
	} ssr_ques_cond_type;

	typedef struct packed {
		logic std_event_summary;
		logic message_available_bit;
		logic aux_bit4;
	} ssr_ext_sum_type;

endpackage : ssr_pkg
`default_nettype wire

// ### testbench/ssr_status_summary_assertions.sv
// concurrent checks on the status summary block ports
`default_nettype none
module ssr_status_summary_assertions #(
	parameter int NUM_CH = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// conditions and commands
	input wire ssr_pkg::ssr_oper_cond_type oper_cond,
	input wire ssr_pkg::ssr_ques_cond_type ques_cond,
	input wire ssr_pkg::ssr_ext_sum_type ext_sum,
	input wire ssr_pkg::ssr_req_type req,
	input wire ssr_pkg::ssr_rsp_type rsp,
	// status byte
	input wire logic [7:0] status_summary_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [15:0] hit = req.valid ? 16'h0001 << req.op : 16'h0000;
	wire logic [15:0] ow = {6'h00, oper_cond.meas_done, oper_cond.pretrig_met,
		2'h0, oper_cond.awaiting_trig, 4'h0, oper_cond.cal_active};
	wire logic [15:0] qw = {3'h0, ques_cond.limit_fail & 4'((1 << NUM_CH) - 1),
		ques_cond.cal_fail, 7'h00, ques_cond.overload};
	// enables shadowed so readback and masking can be judged
	logic [15:0] eo_r;
	logic [15:0] eq_r;
	wire logic [15:0] eo_nxt = hit[3] ? req.data : hit[8] ? 16'h0000 : eo_r;
	wire logic [15:0] eq_nxt = hit[7] ? req.data : hit[8] ? 16'h0000 : eq_r;
	wire logic [7:0] stb = status_summary_byte;
	always_ff @(posedge clock) begin
		eo_r <= rst_b ? eo_nxt : 16'h0000;
		eq_r <= rst_b ? eq_nxt : 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_ans; req.valid |=> rsp.valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_ocond; hit[0] |=> rsp.data == $past(ow, 2); endproperty
	a_ocond: assert property (p_ocond) else $error("oper cond");
	property p_qcond; hit[4] |=> rsp.data == $past(qw, 2); endproperty
	a_qcond: assert property (p_qcond) else $error("ques cond");
	property p_oen; hit[2] |=> rsp.data == eo_r; endproperty
	a_oen: assert property (p_oen) else $error("oper enable");
	property p_qen; hit[6] |=> rsp.data == eq_r; endproperty
	a_qen: assert property (p_qen) else $error("ques enable");
	property p_omask; $past(eo_r) == 16'h0000 |-> !stb[7]; endproperty
	a_omask: assert property (p_omask) else $error("oper mask");
	property p_qmask; $past(eq_r) == 16'h0000 |-> !stb[3]; endproperty
	a_qmask: assert property (p_qmask) else $error("ques mask");
	property p_osum; $past(ow[0], 2) && $past(eo_r[0]) |-> stb[7]; endproperty
	a_osum: assert property (p_osum) else $error("oper sum");
	property p_ext;
		$past(rst_b) |-> {stb[6:4], stb[2:0]} == {$past(ext_sum), 3'h0};
	endproperty
	a_ext: assert property (p_ext) else $error("byte layout");
endmodule : ssr_status_summary_assertions
`default_nettype wire

// ### testbench/ssr_host_model.sv
// host model issuing status commands
`default_nettype none
module ssr_host_model (
	// clock
	input wire logic clock,
	// command port
	output var ssr_pkg::ssr_req_type req,
	input wire ssr_pkg::ssr_rsp_type rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	// idle fields inverted so a stale command cannot pass for a live one
	task automatic send(input logic [3:0] op, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge clock);
		req <= {1'b1, ssr_pkg::ssr_cmd_type'(op), d};
		@(negedge clock);
		req <= {1'b0, ssr_pkg::ssr_cmd_type'(~op), ~d};
		// answer stands one cycle only; a missing one reads unknown
		q = rsp.valid ? rsp.data : 16'hxxxx;
		@(negedge clock);
	endtask : send
endmodule : ssr_host_model
`default_nettype wire

// ### testbench/status_summary_reporting_tb_top.sv
// testbench for the status summary block
`default_nettype none
module status_summary_reporting_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	ssr_pkg::ssr_oper_cond_type oper_cond = '0;
	ssr_pkg::ssr_ques_cond_type ques_cond = '0;
	ssr_pkg::ssr_ext_sum_type ext_sum = '0;
	ssr_pkg::ssr_req_type req;
	ssr_pkg::ssr_rsp_type rsp;
	logic [7:0] stb;
	logic [15:0] q;
	int err_count = 0;
	int n_tests = 0;
	initial begin
		forever #2 clock = ~clock;
	end
	ssr_status_summary #(.NUM_CH(4)) uut (.clock(clock), .rst_b(rst_b),
		.oper_cond(oper_cond), .ques_cond(ques_cond), .ext_sum(ext_sum),
		.req(req), .rsp(rsp), .status_summary_byte(stb));
	ssr_host_model host (.clock(clock), .req(req), .rsp(rsp));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic stop_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	// each condition alone, then the latched events read and cleared
	task automatic t_cond();
		logic [15:0] ow [4] = '{16'h0001, 16'h0020, 16'h0100, 16'h0200};
		for (int i = 0; i < 6; i++) begin
			ques_cond = 6'(1 << i);
			oper_cond = 4'(1 << i);
			host.send(4'h4, 16'h0000, q);
			chk("ques cond", (i > 0) ? 16'h0080 << i : 16'h0001, q);
			host.send(4'h0, 16'h0000, q);
			chk("oper cond", (i < 4) ? ow[i] : 16'h0000, q);
		end
		ques_cond = '0;
		oper_cond = '0;
		host.send(4'h5, 16'h0000, q);
		chk("ques event", 16'h1f01, q);
		host.send(4'h5, 16'h0000, q);
		chk("ques event", 16'h0000, q);
		host.send(4'h1, 16'h0000, q);
		chk("oper event", 16'h0321, q);
		host.send(4'h1, 16'h0000, q);
		chk("oper event", 16'h0000, q);
	endtask : t_cond
	// mask, unmask, readback and preset on one group
	task automatic t_mask(input logic [3:0] b, input int s);
		oper_cond = 4'(b == 4'h0);
		ques_cond = 6'(b == 4'h4);
		repeat (3) @(negedge clock);
		chk("masked sum", 16'h0000, 16'(stb[s]));
		host.send(b + 4'h3, 16'h0001, q);
		chk("sum", 16'h0001, 16'(stb[s]));
		host.send(b + 4'h2, 16'h0000, q);
		chk("enable", 16'h0001, q);
		oper_cond = '0;
		ques_cond = '0;
		host.send(4'h8, 16'h0000, q);
		host.send(b + 4'h2, 16'h0000, q);
		chk("preset enable", 16'h0000, q);
		chk("preset sum", 16'h0000, 16'(stb[s]));
		host.send(b + 4'h1, 16'h0000, q);
		chk("event kept", 16'h0001, q);
	endtask : t_mask
	task automatic t_byte();
		ext_sum = 3'h7;
		host.send(4'h9, 16'h0000, q);
		chk("status byte", 16'h0070, q);
		host.send(4'hf, 16'hffff, q);
		chk("unknown op", 16'h0000, q);
		host.send(4'h2, 16'h0000, q);
		chk("enable kept", 16'h0000, q);
	endtask : t_byte
	initial begin
		repeat (16) @(negedge clock);
		rst_b = 1'b1;
		t_cond();
		t_mask(4'h0, 7);
		t_mask(4'h4, 3);
		t_byte();
		stop_test();
	end
	initial begin
		#20000;
		err_count++;
		stop_test();
	end
endmodule : status_summary_reporting_tb_top
bind ssr_status_summary ssr_status_summary_assertions #(.NUM_CH(NUM_CH))
	u_chk (.clock(clock), .rst_b(rst_b), .oper_cond(oper_cond),
	.ques_cond(ques_cond), .ext_sum(ext_sum), .req(req), .rsp(rsp),
	.status_summary_byte(status_summary_byte));
`default_nettype wire
